// ### flash_pkg.sv
// Shared constants, types and reset values for the flash config block
package flash_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int BUSY_TIME_NS = 3000;
  localparam int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BUSY_LOAD = 8'(BUSY_CYCLES);

  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_EN4B = 8'hB7;
  localparam logic [7:0] OP_EX4B = 8'hE9;
  localparam logic [7:0] OP_WREAR = 8'hC5;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE = 8'hD8;
  localparam logic [7:0] OP_CE = 8'hC7;

  localparam int SR1_BP_LSB = 2;
  localparam int SR1_TB_BIT = 6;
  localparam int SR2_CMP_BIT = 6;
  localparam int SR3_ADS_BIT = 0;
  localparam int SR3_ADP_BIT = 1;
  localparam int SR3_WPS_BIT = 2;
  localparam int SR3_DRV_LSB = 5;
  localparam logic [7:0] SR3_RSV_MASK = 8'h98;

  localparam int BLK_MSB = 24;
  localparam int BLK_LSB = 16;
  localparam logic [8:0] LAST_BLOCK = 9'h1FF;
  localparam logic [3:0] BP_ALL_MIN = 4'hA;
  localparam logic [2:0] NB_MAX = 3'h7;

  localparam logic [1:0] DRV_RST = 2'h0;
  localparam logic [7:0] EXT_RST = 8'h00;

  typedef enum logic [1:0] {PH_IDLE = 2'b01, PH_BUSY = 2'b10} phase_e;

  typedef struct packed {
    logic [7:0] code;
    logic [24:0] addr;
  } op_s;

  typedef struct packed {
    logic [3:0] bp;
    logic tb;
    logic cmp;
    logic protect_scheme_select;
  } prot_cfg_s;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic cs_lvl;
    logic [2:0] tgl_sync;
    logic tgl_seen;
    logic init;
    phase_e phase;
    logic [7:0] busy_cnt;
    logic [2:0] nbytes;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [7:0] data;
    logic wel;
    logic current_addr_mode_flag;
    logic powerup_addr_mode_bit;
    prot_cfg_s prot;
    logic [1:0] drv;
    logic [6:0] drv_pct;
    logic [7:0] ext;
    logic [511:0] locks;
    logic start;
    logic reject;
    op_s op;
  } core_s;

  localparam core_s CORE_RST = '{cs_sync: 3'h7, cs_lvl: 1'b1, init: 1'b1,
    phase: PH_IDLE, drv: DRV_RST, drv_pct: 7'd100, ext: EXT_RST,
    locks: {512{1'b1}}, default: '0};

  function automatic logic [6:0] drive_percent(input logic [1:0] code);
    drive_percent = 7'(7'd100 - 7'd25 * {5'h00, code});
  endfunction

endpackage

// ### spi_byte_rx.sv
// Serial-clock side byte receiver with toggle hand-off to the core clock
`timescale 1ns/1ps
module spi_byte_rx
  import flash_pkg::*;
(
  input wire logic sclk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic [7:0] rx_byte_out,
  output logic rx_tgl_out
);

  typedef struct packed {
    logic [6:0] shift;
    logic [7:0] hold;
    logic tgl;
  } rx_s;

  rx_s st_reg;
  rx_s st_next;
  logic [2:0] bit_cnt_reg;

  // Hold stays stable a full byte time, long enough for the core to see the toggle
  always_comb begin
    st_next = st_reg;
    st_next.shift = {st_reg.shift[5:0], mosi_in};
    if (bit_cnt_reg == 3'h7) begin
      st_next.hold = {st_reg.shift, mosi_in};
      st_next.tgl = ~st_reg.tgl;
    end
  end

  always_ff @(posedge sclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Frame end clears the bit position; no serial edge follows a frame
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt_reg <= 3'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  assign rx_byte_out = st_reg.hold;
  assign rx_tgl_out = st_reg.tgl;

endmodule

// ### protect_range_check.sv
// Decides whether a block span touches protected array space
`timescale 1ns/1ps
module protect_range_check
  import flash_pkg::*;
(
  input prot_cfg_s cfg_in,
  input wire logic [511:0] locks_in,
  input wire logic [8:0] start_blk_in,
  input wire logic [8:0] end_blk_in,
  output logic hit_out
);

  logic none;
  logic [8:0] lo;
  logic [8:0] hi;
  logic [8:0] size;
  logic lock_hit;

  always_comb begin
    none = 1'b0;
    lo = 9'h000;
    hi = LAST_BLOCK;
    size = 9'h001 << (cfg_in.bp - 4'h1);
    lock_hit = 1'b0;
    if (cfg_in.bp == 4'h0) begin
      none = 1'b1;
    end else if (cfg_in.bp < BP_ALL_MIN && (cfg_in.bp[3:1] != 3'b110)) begin
      if (cfg_in.tb) begin
        hi = size - 9'h001;
      end else begin
        lo = LAST_BLOCK - size + 9'h001;
      end
    end
    for (int i = 0; i < 512; i++) begin
      if (locks_in[i] && 9'(i) >= start_blk_in && 9'(i) <= end_blk_in) begin
        lock_hit = 1'b1;
      end
    end
    if (cfg_in.protect_scheme_select) begin
      hit_out = lock_hit;
    end else if (cfg_in.cmp) begin
      hit_out = none || start_blk_in < lo || end_blk_in > hi;
    end else begin
      hit_out = !none && start_blk_in <= hi && end_blk_in >= lo;
    end
  end

endmodule

// ### flash_addr_mode_and_protect_decode.sv
// Address mode, protection select and program/erase gate of a serial flash
`timescale 1ns/1ps
// Behaviour
// - Current address mode flag reads 0 in three-byte, 1 in four-byte mode.
// - Power-up address mode bit is used only at reset initialisation.
// - Power-up address mode bit changes only by write enable then status-3 write.
// - Bit at 0 starts three-byte mode; upper memory needs the extended address.
// - Bit at 1 starts four-byte mode directly, without entry instruction.
// - Scheme select 0 protects from complement, top/bottom and block-protect code.
// - Scheme select 1 protects from individual block lock bits.
// - All block lock bits are set after power-on and every reset.
// - Drive field 00,01,10,11 gives 100, 75, 50, 25 percent.
// - Reserved status bits ignore writes; host ignores them and writes 0.
// - Top side: codes 1 to 9 protect top 1 to 256 blocks.
// - Bottom side: codes 1 to 9 protect bottom 1 to 256 blocks.
// - Code 0 protects nothing; codes 110x and 1x1x protect everything.
// - Program or erase touching protected space is ignored.
// - Complement bit inverts the chosen protected range.
// - Three-byte mode takes the top address bit from bit 0 of the extended register.
// - Enter four-byte instruction switches mode; extended register then ignored.
module flash_addr_mode_and_protect_decode
  import flash_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic soft_reset_in,
  input wire logic lock_set_in,
  input wire logic lock_clr_in,
  input wire logic [8:0] lock_idx_in,
  output logic current_addr_mode_flag_out,
  output logic powerup_addr_mode_bit_out,
  output logic protect_scheme_select_out,
  output logic [1:0] drive_strength_field_out,
  output logic [6:0] drive_percent_out,
  output logic complement_protect_bit_out,
  output logic top_bottom_select_out,
  output logic [3:0] block_protect_code_out,
  output logic [7:0] ext_addr_out,
  output logic [7:0] status3_out,
  output logic wel_out,
  output logic busy_out,
  output logic op_start_out,
  output op_s op_out,
  output logic op_reject_out
);

  ////////////////////////////////////////////////////////////////////////////
  core_s st_reg;
  core_s st_next;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic prot_hit;
  logic [8:0] chk_start;
  logic [8:0] chk_end;
  logic [24:0] full_addr;
  logic [2:0] alen;
  logic lvl_next;
  logic byte_evt;
  logic frame_end;
  logic is_pe;
  logic exec;
  logic [7:0] s3;

  spi_byte_rx u_rx (
    .sclk_in(sclk_in),
    .rstn_in(rstn_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .rx_byte_out(rx_byte),
    .rx_tgl_out(rx_tgl)
  );

  protect_range_check u_chk (
    .cfg_in(st_reg.prot),
    .locks_in(st_reg.locks),
    .start_blk_in(chk_start),
    .end_blk_in(chk_end),
    .hit_out(prot_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Span decode ahead of any state change
  always_comb begin
    alen = st_reg.current_addr_mode_flag ? 3'h4 : 3'h3;
    if (st_reg.current_addr_mode_flag) begin
      full_addr = st_reg.addr[24:0];
    end else begin
      full_addr = {st_reg.ext[0], st_reg.addr[23:0]};
    end
    is_pe = (st_reg.opcode == OP_PP) || (st_reg.opcode == OP_SE)
      || (st_reg.opcode == OP_BE) || (st_reg.opcode == OP_CE);
    if (st_reg.opcode == OP_CE) begin
      chk_start = 9'h000;
      chk_end = LAST_BLOCK;
    end else begin
      chk_start = full_addr[BLK_MSB:BLK_LSB];
      chk_end = full_addr[BLK_MSB:BLK_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.reject = 1'b0;
    // Slow link: a change counts only once the last two stages agree
    st_next.cs_sync = {st_reg.cs_sync[1:0], cs_n_in};
    st_next.tgl_sync = {st_reg.tgl_sync[1:0], rx_tgl};
    lvl_next = st_reg.cs_lvl;
    if (st_reg.cs_sync[1] == st_reg.cs_sync[2]) begin
      lvl_next = st_reg.cs_sync[2];
    end
    st_next.cs_lvl = lvl_next;
    byte_evt = (st_reg.tgl_sync[1] == st_reg.tgl_sync[2])
      && (st_reg.tgl_sync[2] != st_reg.tgl_seen);
    if (byte_evt) begin
      st_next.tgl_seen = st_reg.tgl_sync[2];
    end
    frame_end = !st_reg.cs_lvl && lvl_next;
    exec = frame_end && (st_reg.phase == PH_IDLE) && !st_reg.init;

    if (st_reg.cs_lvl && !lvl_next) begin
      st_next.nbytes = 3'h0;
    end else if (byte_evt) begin
      if (st_reg.nbytes == 3'h0) begin
        st_next.opcode = rx_byte;
      end else if (st_reg.nbytes <= alen) begin
        st_next.addr = {st_reg.addr[23:0], rx_byte};
      end
      if (st_reg.nbytes == 3'h1) begin
        st_next.data = rx_byte;
      end
      if (st_reg.nbytes != NB_MAX) begin
        st_next.nbytes = st_reg.nbytes + 3'h1;
      end
    end

    // Busy window; instructions at frame end are dropped meanwhile
    if (st_reg.phase == PH_BUSY) begin
      st_next.busy_cnt = st_reg.busy_cnt - 8'h01;
      if (st_reg.busy_cnt == 8'h01) begin
        st_next.phase = PH_IDLE;
      end
    end

    if (st_reg.init) begin
      st_next.current_addr_mode_flag = st_reg.powerup_addr_mode_bit;
      st_next.init = 1'b0;
    end

    if (exec) begin
      unique case (st_reg.opcode)
        OP_WREN: begin
          if (st_reg.nbytes == 3'h1) begin
            st_next.wel = 1'b1;
          end
        end
        OP_WRDI: begin
          st_next.wel = 1'b0;
        end
        OP_WRSR1, OP_WRSR2, OP_WRSR3: begin
          if (st_reg.nbytes == 3'h2 && st_reg.wel) begin
            if (st_reg.opcode == OP_WRSR1) begin
              st_next.prot.bp = st_reg.data[SR1_BP_LSB +: 4];
              st_next.prot.tb = st_reg.data[SR1_TB_BIT];
            end else if (st_reg.opcode == OP_WRSR2) begin
              st_next.prot.cmp = st_reg.data[SR2_CMP_BIT];
            end else begin
              // Reserved and mode-flag bits of the byte are dropped
              st_next.powerup_addr_mode_bit = st_reg.data[SR3_ADP_BIT];
              st_next.prot.protect_scheme_select = st_reg.data[SR3_WPS_BIT];
              st_next.drv = st_reg.data[SR3_DRV_LSB +: 2];
            end
            st_next.wel = 1'b0;
            st_next.phase = PH_BUSY;
            st_next.busy_cnt = BUSY_LOAD;
          end
        end
        OP_EN4B: begin
          if (st_reg.nbytes == 3'h1) begin
            st_next.current_addr_mode_flag = 1'b1;
          end
        end
        OP_EX4B: begin
          if (st_reg.nbytes == 3'h1) begin
            st_next.current_addr_mode_flag = 1'b0;
          end
        end
        OP_WREAR: begin
          if (st_reg.nbytes == 3'h2) begin
            st_next.ext = st_reg.data;
          end
        end
        default: begin
        end
      endcase

      if (is_pe && st_reg.wel
          && ((st_reg.opcode == OP_CE && st_reg.nbytes == 3'h1)
          || (st_reg.opcode == OP_PP && st_reg.nbytes >= alen + 3'h2)
          || ((st_reg.opcode == OP_SE || st_reg.opcode == OP_BE)
          && st_reg.nbytes == alen + 3'h1))) begin
        if (prot_hit) begin
          st_next.reject = 1'b1;
        end else begin
          st_next.start = 1'b1;
          st_next.op.code = st_reg.opcode;
          st_next.op.addr = full_addr;
          st_next.wel = 1'b0;
          st_next.phase = PH_BUSY;
          st_next.busy_cnt = BUSY_LOAD;
          if (st_reg.current_addr_mode_flag && st_reg.opcode != OP_CE) begin
            st_next.ext = st_reg.addr[31:24];
          end
        end
      end
    end

    // Lock array edits only while idle so a running check sees fixed bits
    if (st_reg.phase == PH_IDLE) begin
      if (lock_set_in) begin
        st_next.locks[lock_idx_in] = 1'b1;
      end else if (lock_clr_in) begin
        st_next.locks[lock_idx_in] = 1'b0;
      end
    end

    if (soft_reset_in) begin
      st_next.locks = {512{1'b1}};
      st_next.ext = EXT_RST;
      st_next.wel = 1'b0;
      st_next.init = 1'b1;
    end
    st_next.drv_pct = drive_percent(st_next.drv);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= CORE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s3 = 8'h00;
    s3[SR3_ADS_BIT] = st_reg.current_addr_mode_flag;
    s3[SR3_ADP_BIT] = st_reg.powerup_addr_mode_bit;
    s3[SR3_WPS_BIT] = st_reg.prot.protect_scheme_select;
    s3[SR3_DRV_LSB +: 2] = st_reg.drv;
  end

  assign current_addr_mode_flag_out = st_reg.current_addr_mode_flag;
  assign powerup_addr_mode_bit_out = st_reg.powerup_addr_mode_bit;
  assign protect_scheme_select_out = st_reg.prot.protect_scheme_select;
  assign drive_strength_field_out = st_reg.drv;
  assign drive_percent_out = st_reg.drv_pct;
  assign complement_protect_bit_out = st_reg.prot.cmp;
  assign top_bottom_select_out = st_reg.prot.tb;
  assign block_protect_code_out = st_reg.prot.bp;
  assign ext_addr_out = st_reg.ext;
  assign status3_out = s3;
  assign wel_out = st_reg.wel;
  assign busy_out = (st_reg.phase == PH_BUSY);
  assign op_start_out = st_reg.start;
  assign op_out = st_reg.op;
  assign op_reject_out = st_reg.reject;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_mode_flag_b7: assert property (exec && st_reg.opcode == OP_EN4B
    && st_reg.nbytes == 3'h1 |=> current_addr_mode_flag_out && status3_out[0])
    else $error("four-byte entry not reflected");
  a_init_loads_adp: assert property (st_reg.init && !soft_reset_in
    |=> current_addr_mode_flag_out == $past(st_reg.powerup_addr_mode_bit))
    else $error("start mode differs from power-up bit");
  a_adp_write_path: assert property ($changed(st_reg.powerup_addr_mode_bit)
    |-> $past(st_reg.wel) && $past(st_reg.opcode) == OP_WRSR3 && busy_out)
    else $error("power-up bit changed outside status-3 write");
  a_reject_no_busy: assert property (op_reject_out
    |-> !busy_out && !op_start_out && $past(prot_hit))
    else $error("rejected command started or went busy");
  a_protected_rejected: assert property (exec && is_pe && prot_hit
    |=> !op_start_out)
    else $error("protected span started an operation");
  a_busy_holds: assert property (op_start_out |-> busy_out [*8])
    else $error("busy window too short");
  a_drive_decode: assert property (drive_percent_out == (
    (drive_strength_field_out == 2'h0) ? 7'h64
    : (drive_strength_field_out == 2'h1) ? 7'h4B
    : (drive_strength_field_out == 2'h2) ? 7'h32 : 7'h19))
    else $error("drive percent mismatch");
  a_reserved_zero: assert property ((status3_out & SR3_RSV_MASK) == 8'h00)
    else $error("reserved bit reads one");
  a_locks_after_init: assert property ($fell(st_reg.init) |-> &st_reg.locks)
    else $error("lock bits not all set after reset");
  a_ext_upper_bit: assert property (op_start_out && !current_addr_mode_flag_out
    |-> op_out.addr[24] == ext_addr_out[0])
    else $error("three-byte address ignores extended register");
  a_none_code: assert property (!st_reg.prot.protect_scheme_select && !st_reg.prot.cmp
    && st_reg.prot.bp == 4'h0 |-> !prot_hit)
    else $error("code zero protects");
  a_all_code: assert property (!st_reg.prot.protect_scheme_select && !st_reg.prot.cmp
    && st_reg.prot.bp >= BP_ALL_MIN |-> prot_hit)
    else $error("full-array code left space open");
  a_cmp_invert: assert property (!st_reg.prot.protect_scheme_select && st_reg.prot.cmp
    && st_reg.prot.bp == 4'h0 |-> prot_hit)
    else $error("complement did not invert empty range");
  a_top_one_block: assert property (!st_reg.prot.protect_scheme_select && !st_reg.prot.cmp
    && !st_reg.prot.tb && st_reg.prot.bp == 4'h1 |-> prot_hit == (chk_end == LAST_BLOCK))
    else $error("top single block decode wrong");
  a_lock_scheme: assert property (st_reg.prot.protect_scheme_select && st_reg.locks[chk_start]
    |-> prot_hit)
    else $error("locked block not protected");
  a_bottom_one_block: assert property (!st_reg.prot.protect_scheme_select && !st_reg.prot.cmp
    && st_reg.prot.tb && st_reg.prot.bp == 4'h1 |-> prot_hit == (chk_start == 9'h000))
    else $error("bottom single block decode wrong");

  // Side effects of mode changes, rejects and device reset
  a_reject_keeps_wel: assert property (op_reject_out
    |-> wel_out || $past(soft_reset_in))
    else $error("rejected command cleared the write enable latch");
  a_soft_relock: assert property (soft_reset_in |=> &st_reg.locks)
    else $error("device reset left a block unlocked");
  a_mode_change_src: assert property ($changed(current_addr_mode_flag_out)
    |-> $past(st_reg.init) || $past(exec))
    else $error("address mode changed outside init or instruction");
  a_locks_frozen_busy: assert property (busy_out && !soft_reset_in
    |=> $stable(st_reg.locks))
    else $error("lock bits edited during a busy window");

  c_op_start: cover property (op_start_out);
  c_op_reject: cover property (op_reject_out);
  c_four_byte: cover property ($rose(current_addr_mode_flag_out));
  c_busy_done: cover property ($fell(busy_out));
  c_relock: cover property (soft_reset_in ##1 st_reg.init);

endmodule

// ### spi_host_model.sv
// Host model that clocks instruction frames into the flash link
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  logic [7:0] tx_q [$];
  logic [7:0] cur;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Whole bytes only, MSB first, mode 0; clock idles low outside frames
  task automatic send();
    #37;
    cs_n_out = 1'b0;
    while (tx_q.size() > 0) begin
      cur = tx_q.pop_front();
      for (int i = 7; i >= 0; i--) begin
        mosi_out = cur[i];
        #62.5 sclk_out = 1'b1;
        #62.5 sclk_out = 1'b0;
      end
    end
    #62.5 cs_n_out = 1'b1;
    // Released data line must not keep its last value
    mosi_out = ~mosi_out;
    // Gap above the minimum deselect time
    #600;
  endtask
endmodule

// ### tb.sv
// Self-checking bench for the address mode and protection block
`timescale 1ns/1ps
module tb;
  import flash_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic soft_reset_in = 1'b0;
  logic lock_set_in = 1'b0;
  logic lock_clr_in = 1'b0;
  logic [8:0] lock_idx_in = 9'h000;
  logic sclk, cs_n, mosi, current_addr_mode_flag, powerup_addr_mode_bit, protect_scheme_select, cmp, tbs, wel, busy, start, rej;
  logic [1:0] drv;
  logic [6:0] pct;
  logic [3:0] bp;
  logic [7:0] ext, sr3;
  op_s op;
  int bad_count = 0;
  int tests_run = 0;
  int n_start = 0;
  int n_rej = 0;
  logic four_b = 1'b0;

  always #50 clk_in = ~clk_in;

  // Sampled mid-cycle, away from the edge that launches the pulse
  always @(negedge clk_in) begin
    if (start === 1'b1) n_start++;
    if (rej === 1'b1) n_rej++;
  end

  spi_host_model spi_host_model_inst (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));

  flash_addr_mode_and_protect_decode flash_addr_mode_and_protect_decode_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
    .soft_reset_in(soft_reset_in), .lock_set_in(lock_set_in), .lock_clr_in(lock_clr_in),
    .lock_idx_in(lock_idx_in), .current_addr_mode_flag_out(current_addr_mode_flag),
    .powerup_addr_mode_bit_out(powerup_addr_mode_bit), .protect_scheme_select_out(protect_scheme_select),
    .drive_strength_field_out(drv), .drive_percent_out(pct),
    .complement_protect_bit_out(cmp), .top_bottom_select_out(tbs),
    .block_protect_code_out(bp), .ext_addr_out(ext), .status3_out(sr3), .wel_out(wel),
    .busy_out(busy), .op_start_out(start), .op_out(op), .op_reject_out(rej)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d bad=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [7:0] b);
    spi_host_model_inst.tx_q.push_back(b);
  endtask

  // Bounded wait so a stuck busy cannot hang the run
  task automatic settle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 60) begin
      @(negedge clk_in);
      k++;
    end
    chk(32'(k < 60), 32'h1);
  endtask

  task automatic go();
    spi_host_model_inst.send();
    settle();
  endtask

  task automatic cmd(input logic [7:0] c);
    put(c);
    go();
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd(OP_WREN);
    put(c);
    put(d);
    go();
  endtask

  task automatic sreset();
    @(posedge clk_in);
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic lock(input logic [8:0] i, input logic s);
    @(posedge clk_in);
    lock_idx_in <= i;
    lock_set_in <= s;
    lock_clr_in <= ~s;
    @(posedge clk_in);
    lock_set_in <= 1'b0;
    lock_clr_in <= 1'b0;
  endtask

  // Block erase of one 64KB block, judged on pulses, latch and busy
  task automatic erase(input logic [8:0] b, input logic e);
    int s0, r0;
    logic [31:0] a;
    s0 = n_start;
    r0 = n_rej;
    a = {7'h00, b, 16'h0000};
    cmd(OP_WREN);
    put(OP_BE);
    for (int i = four_b ? 3 : 2; i >= 0; i--) put(a[8*i +: 8]);
    spi_host_model_inst.send();
    chk(32'(n_rej - r0), 32'(e));
    chk(32'(n_start - s0), 32'(!e));
    chk(32'(wel), 32'(e));
    chk(32'(busy), 32'(!e));
    settle();
    cmd(OP_WRDI);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(32'(sr3), 32'h0);
    chk(32'(current_addr_mode_flag), 32'h0);
    chk(32'(pct), 32'd100);
    chk(32'(ext), 32'h0);
  endtask

  task automatic t_drive();
    for (int d = 0; d < 4; d++) begin
      // Reserved bits written high on purpose
      wr(OP_WRSR3, 8'h98 | 8'(d << 5));
      chk(32'(drv), 32'(d));
      chk(32'(pct), 32'(100 - 25 * d));
      chk(32'(sr3), 32'(d << 5));
    end
    wr(OP_WRSR3, 8'h00);
  endtask

  task automatic t_mode();
    wr(OP_WRSR3, 8'h02);
    chk(32'(powerup_addr_mode_bit), 32'h1);
    chk(32'(current_addr_mode_flag), 32'h0);
    sreset();
    chk(32'(current_addr_mode_flag), 32'h1);
    put(OP_WRSR3);
    put(8'h00);
    go();
    chk(32'(powerup_addr_mode_bit), 32'h1);
    wr(OP_WRSR3, 8'h00);
    chk(32'(current_addr_mode_flag), 32'h1);
    sreset();
    chk(32'(current_addr_mode_flag), 32'h0);
    cmd(OP_EN4B);
    chk(32'(current_addr_mode_flag), 32'h1);
    chk(32'(sr3), 32'h0000_0001);
    four_b = 1'b1;
  endtask

  task automatic t_range();
    int n;
    for (int t = 0; t < 2; t++) begin
      for (int c = 1; c < 10; c++) begin
        n = 1 << (c - 1);
        wr(OP_WRSR1, 8'((t << 6) | (c << 2)));
        chk(32'(bp), 32'(c));
        chk(32'(tbs), 32'(t));
        erase(9'(t ? n - 1 : 512 - n), 1'b1);
        erase(9'(t ? n : 511 - n), 1'b0);
      end
    end
    for (int c = 10; c < 16; c++) begin
      wr(OP_WRSR1, 8'(((c & 1) << 6) | (c << 2)));
      erase(9'h000, 1'b1);
    end
    wr(OP_WRSR1, 8'h40);
    erase(9'h000, 1'b0);
    chk(32'(op.code), 32'(OP_BE));
    chk(32'(op.addr), 32'h0000_0000);
    erase(9'h1FF, 1'b0);
    wr(OP_WRSR2, 8'h40);
    erase(9'h000, 1'b1);
    wr(OP_WRSR1, 8'h04);
    chk(32'(cmp), 32'h1);
    erase(9'h1FF, 1'b0);
    erase(9'h1FE, 1'b1);
    wr(OP_WRSR2, 8'h00);
  endtask

  task automatic t_locks();
    wr(OP_WRSR3, 8'h04);
    chk(32'(protect_scheme_select), 32'h1);
    wr(OP_WRSR1, 8'h3C);
    erase(9'h007, 1'b1);
    lock(9'h007, 1'b0);
    erase(9'h007, 1'b0);
    lock(9'h007, 1'b1);
    erase(9'h007, 1'b1);
    lock(9'h007, 1'b0);
    // Device reset must relock every block
    sreset();
    four_b = 1'b0;
    erase(9'h007, 1'b1);
  endtask

  task automatic t_ext();
    wr(OP_WRSR3, 8'h00);
    wr(OP_WRSR1, 8'h04);
    put(OP_WREAR);
    put(8'h01);
    go();
    chk(32'(ext), 32'h1);
    erase(9'h0FF, 1'b1);
    put(OP_WREAR);
    put(8'h00);
    go();
    erase(9'h0FF, 1'b0);
    chk(32'(op.addr), 32'h00FF_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #3_000_000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    t_reset();
    t_drive();
    t_mode();
    t_range();
    t_locks();
    t_ext();
    report_and_stop();
  end
endmodule
